//--- sos_top.sv
// status output selector: apb registers, source gathering and status pin
`timescale 1ns/1ps
`include "sos_params.svh"
module sos_top
	import sos_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic primary_reference_loss_of_signal_in,
	input wire logic secondary_reference_loss_of_signal_in,
	input wire logic first_synthesizer_loss_of_lock_in,
	input wire logic second_synthesizer_loss_of_lock_in,
	input wire logic [5:0] divider_tick_in,
	input wire logic [1:0] divider_bypass_in,
	input wire logic [1:0] calibration_active_in,
	input wire logic interrupt_indication_in,
	input wire logic eeprom_active_in,
	input wire logic [1:0] auto_switch_in,
	output logic [1:0] primary_threshold_select_out,
	output logic status_a_pin_out,
	output logic irq_out
);
	////////////////////////////////////////////////////////////////
	// register state
	logic [3:0] status_a_source_select;
	logic status_a_polarity;
	logic [1:0] primary_threshold_select;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;
	logic test_en;
	logic test_val;
	logic [3:0] next_sel;
	logic next_pol;
	logic [1:0] next_lvl;
	logic [2:0] next_irq_status;
	logic [2:0] next_irq_mask;
	logic next_test_en;
	logic next_test_val;
	logic [31:0] next_prdata;
	logic wr_acc;
	logic rd_acc;
	logic mapped;
	logic [2:0] events;
	logic [2:0] prev_events;
	logic [5:0] half;
	logic [15:0] sources;
	sos_sel_if sel_bus ();

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `SOS_OFS_STATUS_SEL) || (a == `SOS_OFS_LEVEL) ||
			(a == `SOS_OFS_IRQ_STATUS) || (a == `SOS_OFS_IRQ_MASK) ||
			(a == `SOS_OFS_TEST_CTRL) || (a == `SOS_OFS_LIVE);
	endfunction : is_mapped

	assign wr_acc = psel_in && penable_in && pwrite_in;
	assign rd_acc = psel_in && penable_in && !pwrite_in;
	assign mapped = is_mapped(paddr_in);
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in && penable_in && !mapped;

	////////////////////////////////////////////////////////////////
	// events: rising edges of both loss-of-lock flags and either auto switch
	assign events = {|auto_switch_in, second_synthesizer_loss_of_lock_in,
		first_synthesizer_loss_of_lock_in};

	always_comb begin
		next_sel = status_a_source_select;
		next_pol = status_a_polarity;
		next_lvl = primary_threshold_select;
		next_irq_mask = irq_mask;
		next_test_en = test_en;
		next_test_val = test_val;
		next_irq_status = irq_status;
		if (wr_acc && pstrb_in[0]) begin
			unique case (paddr_in)
				`SOS_OFS_STATUS_SEL: begin
					// [RL2] source selector write
					next_sel = pwdata_in[`SOS_SEL_MSB:`SOS_SEL_LSB];
					// [RL10] polarity write
					next_pol = pwdata_in[`SOS_POL_BIT];
				end
				`SOS_OFS_LEVEL: begin
					// [RL1] threshold write
					next_lvl = pwdata_in[`SOS_LVL_MSB:`SOS_LVL_LSB];
				end
				`SOS_OFS_IRQ_STATUS: begin
					next_irq_status = irq_status & ~pwdata_in[2:0];
				end
				`SOS_OFS_IRQ_MASK: begin
					next_irq_mask = pwdata_in[2:0];
				end
				`SOS_OFS_TEST_CTRL: begin
					next_test_en = pwdata_in[0];
					next_test_val = pwdata_in[1];
				end
				default: begin
				end
			endcase
		end
		// set wins over clear
		next_irq_status = next_irq_status | (events & ~prev_events);
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			status_a_source_select <= `SOS_SEL_RESET;
			status_a_polarity <= `SOS_POL_RESET;
			primary_threshold_select <= `SOS_LVL_RESET;
			irq_status <= 3'h0;
			irq_mask <= 3'h0;
			test_en <= 1'b0;
			test_val <= 1'b0;
			prev_events <= 3'h0;
		end else begin
			status_a_source_select <= next_sel;
			status_a_polarity <= next_pol;
			primary_threshold_select <= next_lvl;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			test_en <= next_test_en;
			test_val <= next_test_val;
			prev_events <= events;
		end
	end

	// a set mask bit silences its status bit
	assign irq_out = |(irq_status & ~irq_mask);
	assign primary_threshold_select_out = primary_threshold_select;

	////////////////////////////////////////////////////////////////
	// read data
	always_comb begin
		next_prdata = prdata_out;
		if (psel_in && !penable_in && !pwrite_in) begin
			next_prdata = 32'h0000_0000;
			unique case (paddr_in)
				`SOS_OFS_STATUS_SEL: begin
					// [RL12] low bits read zero
					next_prdata[7:0] = {status_a_source_select, status_a_polarity, 3'b000};
				end
				`SOS_OFS_LEVEL: begin
					next_prdata[1:0] = primary_threshold_select;
				end
				`SOS_OFS_IRQ_STATUS: begin
					next_prdata[2:0] = irq_status;
				end
				`SOS_OFS_IRQ_MASK: begin
					next_prdata[2:0] = irq_mask;
				end
				`SOS_OFS_TEST_CTRL: begin
					next_prdata[1:0] = {test_val, test_en};
				end
				`SOS_OFS_LIVE: begin
					next_prdata[0] = status_a_pin_out;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prdata_out <= 32'h0000_0000;
		end else begin
			prdata_out <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// source gathering
	sos_halver u_halver (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.tick_in(divider_tick_in),
		.half_out(half)
	);

	always_comb begin
		// [RL3] loss flags
		sources[SOS_PRI_LOS] = primary_reference_loss_of_signal_in;
		sources[SOS_SEC_LOS] = secondary_reference_loss_of_signal_in;
		sources[SOS_S1_LOL] = first_synthesizer_loss_of_lock_in;
		// [RL4] first synthesizer dividers
		sources[SOS_S1_RDIV] = half[0] & ~divider_bypass_in[0];
		sources[SOS_S1_NDIV] = half[1];
		// [RL5] second synthesizer
		sources[SOS_S2_LOL] = second_synthesizer_loss_of_lock_in;
		sources[SOS_S2_RDIV] = half[2] & ~divider_bypass_in[1];
		sources[SOS_S2_NDIV] = half[3];
		// [RL6] calibration activity
		sources[SOS_S1_CAL] = calibration_active_in[0];
		sources[SOS_S2_CAL] = calibration_active_in[1];
		// [RL7] interrupt source
		sources[SOS_IRQ] = interrupt_indication_in;
		// [RL8] phase detector dividers
		sources[SOS_S1_MDIV] = half[4];
		sources[SOS_S2_MDIV] = half[5];
		// [RL9] memory and switch events
		sources[SOS_EEPROM] = eeprom_active_in;
		sources[SOS_S1_SWITCH] = auto_switch_in[0];
		sources[SOS_S2_SWITCH] = auto_switch_in[1];
	end

	assign sel_bus.sel = status_a_source_select;
	assign sel_bus.pol = status_a_polarity;
	assign sel_bus.test_en = test_en;
	assign sel_bus.test_val = test_val;

	sos_status_mux u_mux (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.src_in(sources),
		.cfg(sel_bus.mux),
		.pin_out(status_a_pin_out)
	);

	////////////////////////////////////////////////////////////////
	// checks
	// [RL2] selector reset value
	a_sel_reset_value: assert property (@(posedge clk_in) $rose(resetn_in) |-> // RL2
		status_a_source_select == `SOS_SEL_RESET)
		else $error("selector reset wrong");

	// [RL10] polarity reset value
	a_pol_reset_value: assert property (@(posedge clk_in) $rose(resetn_in) |-> // RL10
		status_a_polarity == `SOS_POL_RESET)
		else $error("polarity reset wrong");

	// [RL1] threshold reset value
	a_lvl_reset_value: assert property (@(posedge clk_in) $rose(resetn_in) |-> // RL1
		primary_threshold_select_out == `SOS_LVL_RESET)
		else $error("threshold reset wrong");

	// [RL1] threshold write lands
	a_lvl_write_takes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL1
		wr_acc && pstrb_in[0] && paddr_in == `SOS_OFS_LEVEL |=>
		primary_threshold_select == $past(pwdata_in[1:0]))
		else $error("level write lost");

	// [RL1] threshold holds otherwise
	a_lvl_holds: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL1
		!(wr_acc && pstrb_in[0] && paddr_in == `SOS_OFS_LEVEL) |=>
		$stable(primary_threshold_select_out))
		else $error("level changed without a write");

	// [RL2] selector write lands
	a_sel_write_takes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL2
		wr_acc && pstrb_in[0] && paddr_in == `SOS_OFS_STATUS_SEL |=>
		status_a_source_select == $past(pwdata_in[`SOS_SEL_MSB:`SOS_SEL_LSB]))
		else $error("selector write lost");

	// [RL2] selector holds otherwise
	a_sel_holds: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL2
		!(wr_acc && pstrb_in[0] && paddr_in == `SOS_OFS_STATUS_SEL) |=>
		$stable(status_a_source_select))
		else $error("selector changed without a write");

	// [RL10] polarity write lands
	a_pol_write_takes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL10
		wr_acc && pstrb_in[0] && paddr_in == `SOS_OFS_STATUS_SEL |=>
		status_a_polarity == $past(pwdata_in[`SOS_POL_BIT]))
		else $error("polarity write lost");

	// [RL12] pin follows selection
	a_pin_follows_src: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL12
		!test_en |=> status_a_pin_out == ($past(sources[status_a_source_select])
		~^ $past(status_a_polarity)))
		else $error("pin mismatch");

	// [RL10] low polarity inverts
	a_pol_inverts: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL10
		!test_en && !status_a_polarity && sources[status_a_source_select] |=>
		!status_a_pin_out)
		else $error("polarity wrong");

	// [RL11] test value overrides
	a_test_override: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL11
		test_en |=> status_a_pin_out == $past(test_val))
		else $error("test not applied");

	// [RL12] reserved bits read zero
	a_low_bits_zero: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL12
		rd_acc && paddr_in == `SOS_OFS_STATUS_SEL |-> prdata_out[2:0] == 3'b000)
		else $error("reserved bits set");

	// [RL3] primary loss routed
	a_los_pri_routes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL3
		status_a_source_select == 4'h0 && status_a_polarity && !test_en |=>
		status_a_pin_out == $past(primary_reference_loss_of_signal_in))
		else $error("primary loss misrouted");

	// [RL3] secondary loss routed
	a_los_sec_routes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL3
		status_a_source_select == 4'h1 && status_a_polarity && !test_en |=>
		status_a_pin_out == $past(secondary_reference_loss_of_signal_in))
		else $error("secondary loss misrouted");

	// [RL3] first lock loss routed
	a_lol1_routes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL3
		status_a_source_select == 4'h2 && status_a_polarity && !test_en
		##1 status_a_source_select == 4'h2 |-> status_a_pin_out ==
		$past(first_synthesizer_loss_of_lock_in)) else $error("lock loss misrouted");

	// [RL4] bypassed reference divider silent
	a_rdiv_bypassed: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL4
		status_a_source_select == 4'h3 && status_a_polarity && !test_en &&
		divider_bypass_in[0] |=> !status_a_pin_out)
		else $error("bypassed divider shown");

	// [RL4] first feedback divider routed
	a_ndiv_routes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL4
		status_a_source_select == 4'h4 && status_a_polarity && !test_en |=>
		status_a_pin_out == $past(half[1]))
		else $error("feedback divider misrouted");

	// [RL5] second lock loss routed
	a_lol2_routes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL5
		status_a_source_select == 4'h5 && status_a_polarity && !test_en |=>
		status_a_pin_out == $past(second_synthesizer_loss_of_lock_in))
		else $error("second lock loss misrouted");

	// [RL5] second bypassed divider silent
	a_s2_rdiv_bypassed: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL5
		status_a_source_select == 4'h6 && status_a_polarity && !test_en &&
		divider_bypass_in[1] |=> !status_a_pin_out)
		else $error("second bypassed divider shown");

	// [RL4] [RL5] [RL8] ticks halve dividers
	a_div_halves: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL4 RL5 RL8
		divider_tick_in != 6'h00 |=>
		half == ($past(half) ^ $past(divider_tick_in)))
		else $error("divider halving wrong");

	// [RL6] calibration activity routed
	a_cal_routes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL6
		(status_a_source_select == 4'h8 || status_a_source_select == 4'h9) &&
		status_a_polarity && !test_en |=> status_a_pin_out ==
		$past(calibration_active_in[status_a_source_select[0]])) else $error("cal misrouted");

	// [RL7] interrupt routed
	a_irq_routes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL7
		status_a_source_select == 4'hA && status_a_polarity && !test_en
		|=> status_a_pin_out == $past(interrupt_indication_in))
		else $error("irq misrouted");

	// [RL8] phase detector divider routed
	a_mdiv_routes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL8
		status_a_source_select == 4'hB && status_a_polarity && !test_en |=>
		status_a_pin_out == $past(half[4]))
		else $error("phase detector divider misrouted");

	// [RL9] memory activity routed
	a_eeprom_routes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL9
		status_a_source_select == 4'hD && status_a_polarity && !test_en |=>
		status_a_pin_out == $past(eeprom_active_in))
		else $error("memory activity misrouted");

	// [RL9] auto switch routed
	a_switch_routes: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL9
		(status_a_source_select == 4'hE || status_a_source_select == 4'hF) &&
		status_a_polarity && !test_en |=> status_a_pin_out ==
		$past(auto_switch_in[status_a_source_select[0]])) else $error("switch misrouted");
endmodule : sos_top

//--- sos_params.svh
// register offsets, field positions and reset values of the status output selector
// How it works
// [RL1] two-bit primary threshold code: 0=200mV, 1=300mV, 2=400mV, 3 reserved; resets to 1
// [RL2] four-bit source selector in bits 7..4 picks the status pin source; resets to 5
// [RL3] codes 0,1,2: primary signal loss, secondary signal loss, first synthesizer lock loss
// [RL4] code 3: first reference divider halved; code 4: first feedback divider halved
// [RL5] codes 5,6,7: second lock loss, second reference and feedback dividers halved
// [RL6] codes 8 and 9: oscillator calibration active for first and second synthesizer
// [RL7] code 10: interrupt indication formed from the interrupt flag bits; the code routes the interrupt_indication_in port, not irq_out
// [RL8] codes 11,12: phase detector input divider halved, first and second synthesizer
// [RL9] code 13 memory activity; 14,15 automatic secondary-to-primary switch per synthesizer
// [RL10] polarity bit 3 set gives active high output, clear gives active low; resets to 1
// [RL11] active test configuration overrides the selection and drives the pin instead
// [RL12] sixteen-way multiplexer then conditional inversion; bits 2..0 read zero, ignore writes
`ifndef SOS_PARAMS_SVH
`define SOS_PARAMS_SVH
`define SOS_OFS_STATUS_SEL 12'h06C
`define SOS_IDX_STATUS_SEL 8'h1B
`define SOS_OFS_LEVEL 12'h100
`define SOS_OFS_IRQ_STATUS 12'h104
`define SOS_OFS_IRQ_MASK 12'h108
`define SOS_OFS_TEST_CTRL 12'h10C
`define SOS_OFS_LIVE 12'h110
`define SOS_SEL_MSB 7
`define SOS_SEL_LSB 4
`define SOS_POL_BIT 3
`define SOS_LVL_MSB 1
`define SOS_LVL_LSB 0
`define SOS_SEL_RESET 4'h5
`define SOS_POL_RESET 1'b1
`define SOS_LVL_RESET 2'h1
`define SOS_LVL_RESERVED 2'h3
`define SOS_IRQ_BITS 3
`endif

//--- sos_pkg.sv
// types shared by the status output selector
package sos_pkg;
	typedef enum logic [3:0] {
		SOS_PRI_LOS, SOS_SEC_LOS, SOS_S1_LOL, SOS_S1_RDIV, SOS_S1_NDIV, SOS_S2_LOL,
		SOS_S2_RDIV, SOS_S2_NDIV, SOS_S1_CAL, SOS_S2_CAL, SOS_IRQ, SOS_S1_MDIV,
		SOS_S2_MDIV, SOS_EEPROM, SOS_S1_SWITCH, SOS_S2_SWITCH
	} sos_source_t;
	typedef enum logic [1:0] {
		SOS_LVL_200MV, SOS_LVL_300MV, SOS_LVL_400MV, SOS_LVL_RSVD
	} sos_level_t;
endpackage : sos_pkg

//--- sos_sel_if.sv
// selection signals passed from the register file to the output stage
`timescale 1ns/1ps
interface sos_sel_if;
	logic [3:0] sel;
	logic pol;
	logic test_en;
	logic test_val;
	modport regs (output sel, output pol, output test_en, output test_val);
	modport mux (input sel, input pol, input test_en, input test_val);
endinterface : sos_sel_if

//--- sos_halver.sv
// divide-by-two toggles for the six divider tap strobes
`timescale 1ns/1ps
module sos_halver (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [5:0] tick_in,
	output logic [5:0] half_out
);
	logic [5:0] next_half;
	always_comb begin
		next_half = half_out ^ tick_in;
	end
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			half_out <= 6'h00;
		end else begin
			half_out <= next_half;
		end
	end
endmodule : sos_halver

//--- sos_status_mux.sv
// source multiplexer with polarity and test override
`timescale 1ns/1ps
module sos_status_mux
	import sos_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [15:0] src_in,
	sos_sel_if.mux cfg,
	output logic pin_out
);
	logic next_pin;
	logic picked;
	always_comb begin
		// [RL12] pick then invert
		picked = src_in[cfg.sel];
		// [RL10] polarity inversion
		next_pin = cfg.pol ? picked : ~picked;
		// [RL11] test override
		if (cfg.test_en) begin
			next_pin = cfg.test_val;
		end
	end
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pin_out <= 1'b0;
		end else begin
			pin_out <= next_pin;
		end
	end
endmodule : sos_status_mux

//--- sos_board_model.sv
// board logic that samples the status pin
`timescale 1ns/1ps
module sos_board_model (
	input wire logic clk_in,
	input wire logic pin_in,
	output logic seen_out
);
	// board latch of the pin on each system clock
	always_ff @(posedge clk_in) begin
		seen_out <= pin_in;
	end
endmodule : sos_board_model

//--- tb_status_output_select.sv
// self-checking bench for the status output selector
`timescale 1ns/1ps
module tb_status_output_select;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0000_0000;
	logic [3:0] pst = 4'h0;
	logic [31:0] prdata;
	logic [31:0] rdv;
	logic pready, pslverr, pin, irq, seen, e;
	logic [1:0] thr;
	logic [15:0] src = 16'h0000;
	logic [5:0] tick = 6'h00;
	logic [5:0] hv = 6'h00;
	logic [1:0] byp = 2'h0;
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	always #25 clk_in = ~clk_in;
	sos_top sos_top_inst (
		.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(pst),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.primary_reference_loss_of_signal_in(src[0]),
		.secondary_reference_loss_of_signal_in(src[1]),
		.first_synthesizer_loss_of_lock_in(src[2]),
		.second_synthesizer_loss_of_lock_in(src[5]),
		.divider_tick_in(tick), .divider_bypass_in(byp),
		.calibration_active_in(src[9:8]), .interrupt_indication_in(src[10]),
		.eeprom_active_in(src[13]), .auto_switch_in(src[15:14]),
		.primary_threshold_select_out(thr), .status_a_pin_out(pin), .irq_out(irq)
	);
	sos_board_model sos_board_model_inst (.clk_in(clk_in), .pin_in(pin), .seen_out(seen));
	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, x);
		end
	endtask : chk
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic er);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		pst <= 4'hF;
		@(posedge clk_in);
		pen <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		// idle edge so the next call never re-raises psel in this time step
		@(posedge clk_in);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rdv, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000, rdv, e);
		chk(rdv, x);
	endtask : rd
	task automatic st(input logic x);
		repeat (4) @(posedge clk_in);
		chk(seen, x);
	endtask : st
	task automatic ci(input logic x);
		@(posedge clk_in);
		chk(irq, x);
	endtask : ci
	task automatic pulse(input int i);
		tick[i] <= 1'b1;
		@(posedge clk_in);
		tick[i] <= 1'b0;
		hv[i] = ~hv[i];
	endtask : pulse
	function automatic int tix(input int c);
		case (c)
			3: return 0;
			4: return 1;
			6: return 2;
			7: return 3;
			11: return 4;
			12: return 5;
			default: return -1;
		endcase
	endfunction : tix
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		rd(12'h06C, 32'h0000_0058);
		rd(12'h100, 32'h0000_0001);
		chk(thr, 32'h0000_0001);
		st(1'b0);
		rd(12'h108, 32'h0000_0000);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			wr(12'h100, 32'(i));
			rd(12'h100, 32'(i));
			chk(thr, 32'(i));
		end
		wr(12'h06C, 32'h0000_00FF);
		rd(12'h06C, 32'h0000_00F8);
		apb(1'b0, 12'h200, 32'h0000_0000, rdv, e);
		chk(e, 32'h0000_0001);
		chk(rdv, 32'h0000_0000);
		$display("test registers done");
		for (int c = 0; c < 16; c++) begin
			for (int p = 0; p < 2; p++) begin
				wr(12'h06C, 32'(c * 16 + p * 8));
				if (tix(c) < 0) begin
					src <= 16'h0001 << c;
					st(p[0]);
					src <= 16'h0000;
					st(!p[0]);
				end else begin
					pulse(tix(c));
					st(hv[tix(c)] ^ !p[0]);
					pulse(tix(c));
					st(hv[tix(c)] ^ !p[0]);
				end
			end
		end
		$display("test sources done");
		wr(12'h104, 32'h0000_0007);
		ci(1'b0);
		src <= 16'h0004;
		repeat (3) @(posedge clk_in);
		rd(12'h104, 32'h0000_0001);
		ci(1'b1);
		wr(12'h108, 32'h0000_0001);
		ci(1'b0);
		wr(12'h108, 32'h0000_0000);
		ci(1'b1);
		wr(12'h104, 32'h0000_0001);
		ci(1'b0);
		src <= 16'h0000;
		$display("test interrupt done");
		wr(12'h10C, 32'h0000_0003);
		st(1'b1);
		rd(12'h110, 32'h0000_0001);
		wr(12'h10C, 32'h0000_0001);
		st(1'b0);
		wr(12'h10C, 32'h0000_0000);
		$display("test override done");
		wr(12'h06C, 32'h0000_0038);
		byp <= 2'h1;
		pulse(0);
		st(1'b0);
		pulse(0);
		st(1'b0);
		$display("test bypass done");
		summarize();
	end
endmodule : tb_status_output_select
